// *** hdl/iorsd_consts.svh ***
`ifndef IORSD_CONSTS_SVH
`define IORSD_CONSTS_SVH
// Functional notes
// - Short-form in and out instructions reach exactly I/O locations 0x00 to 0x3F.
// - A low I/O register seen through data space sits at its I/O address plus 0x20.
// - Single-bit set and clear act only on I/O locations 0x00 to 0x1F, others ignore them.
// - Skip-if-bit tests can read any single bit of locations 0x00 to 0x1F.
// - Some status flags clear when a one is written to them, a zero leaves them alone.
// - Single-bit set or clear changes only the addressed bit, never clears other flags.
// - Extended space 0x60 to 0xFF is reached by data loads and stores only.

// ==========================================
// Address views
`define IORSD_DATA_OFFSET 8'h20
`define IORSD_IO_TOP 8'h3F
`define IORSD_BIT_TOP 8'h1F
`define IORSD_EXT_BASE 8'h60

// ==========================================
// Register offsets, short I/O view
`define IORSD_PIN_GROUP_B_INPUT_LEVEL 6'h03
`define IORSD_PIN_GROUP_B_DIRECTION 6'h04
`define IORSD_PIN_GROUP_B_OUTPUT_LATCH 6'h05
`define IORSD_PIN_GROUP_C_INPUT_LEVEL 6'h06
`define IORSD_PIN_GROUP_C_DIRECTION 6'h07
`define IORSD_PIN_GROUP_C_OUTPUT_LATCH 6'h08
`define IORSD_PIN_GROUP_D_INPUT_LEVEL 6'h09
`define IORSD_PIN_GROUP_D_DIRECTION 6'h0A
`define IORSD_PIN_GROUP_D_OUTPUT_LATCH 6'h0B
`define IORSD_PIN_GROUP_E_INPUT_LEVEL 6'h0C
`define IORSD_PIN_GROUP_E_DIRECTION 6'h0D
`define IORSD_PIN_GROUP_E_OUTPUT_LATCH 6'h0E
`define IORSD_TIMER8_EVENT_FLAGS 6'h15
`define IORSD_TIMER16_EVENT_FLAGS 6'h16
`define IORSD_GENERAL_SCRATCH_ONE 6'h19
`define IORSD_GENERAL_SCRATCH_TWO 6'h1A
`define IORSD_PIN_CHANGE_EVENT_FLAGS 6'h1B
`define IORSD_EXTERNAL_LINE_EVENT_FLAGS 6'h1C
`define IORSD_EXTERNAL_LINE_EVENT_MASK 6'h1D
`define IORSD_GENERAL_SCRATCH_ZERO 6'h1E
`define IORSD_NONVOLATILE_STORE_CONTROL 6'h1F
`define IORSD_NONVOLATILE_STORE_DATA 6'h20
`define IORSD_NONVOLATILE_STORE_ADDR_LOW 6'h21
`define IORSD_NONVOLATILE_STORE_ADDR_HIGH 6'h22
`define IORSD_SHARED_TIMER_CONTROL 6'h23
`define IORSD_TIMER8_CONTROL_FIRST 6'h24
`define IORSD_TIMER8_CONTROL_SECOND 6'h25
`define IORSD_TIMER8_COUNT_VALUE 6'h26
`define IORSD_TIMER8_COMPARE_FIRST 6'h27
`define IORSD_TIMER8_COMPARE_SECOND 6'h28
`define IORSD_PHASE_LOCK_LOOP_CONTROL 6'h29
`define IORSD_SERIAL_PORT_CONTROL 6'h2C
`define IORSD_SERIAL_PORT_STATUS 6'h2D
`define IORSD_SERIAL_PORT_DATA 6'h2E
`define IORSD_COMPARATOR_STATUS 6'h30
`define IORSD_MONITOR_DATA 6'h31
`define IORSD_MONITOR_STOP_CONTROL 6'h32
`define IORSD_SLEEP_CONTROL 6'h33
`define IORSD_RESET_CAUSE_FLAGS 6'h34
`define IORSD_CORE_CONTROL 6'h35
`define IORSD_SELF_PROGRAM_CONTROL 6'h37

// ==========================================
// Implemented bit masks
`define IORSD_NO_BITS 8'h00
`define IORSD_ALL_BITS 8'hFF
`define IORSD_LOW_NIBBLE 8'h0F
`define IORSD_THREE_BITS 8'h07
`define IORSD_TIMER16_FLAG_BITS 8'h27
`define IORSD_STORE_ADDR_HIGH_BITS 8'h03
`define IORSD_SHARED_TIMER_BITS 8'h81
`define IORSD_TIMER8_FIRST_BITS 8'hF3
`define IORSD_TIMER8_SECOND_BITS 8'hCF
`define IORSD_PLL_WRITE_BITS 8'h06
`define IORSD_LOWEST_BIT 8'h01
`define IORSD_SERIAL_STATUS_READ_BITS 8'hC0
`define IORSD_COMPARATOR_FLAG_BITS 8'hF0
`define IORSD_CORE_CONTROL_BITS 8'h93
`define IORSD_SELF_PROGRAM_WRITE_BITS 8'hBF
`define IORSD_SELF_PROGRAM_READ_BITS 8'h40

`endif

// *** hdl/iorsd_pkg.sv ***
package iorsd_pkg;
   typedef enum logic [2:0] {
      io_in_instr,
      io_out_instr,
      indirect_load_instr,
      indirect_store_instr,
      set_single_bit_instr,
      clear_single_bit_instr,
      skip_if_bit_one_instr,
      skip_if_bit_zero_instr
   } iorsd_op_t;
   typedef logic [7:0] iorsd_byte_t;
   typedef logic [63:0][7:0] iorsd_space_t;
endpackage

// *** hdl/iorsd_decoder.sv ***
`timescale 1ns/10ps
`include "iorsd_consts.svh"

module iorsd_decoder
   import iorsd_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Core access request
   input wire logic acc_req,
   input wire iorsd_op_t acc_op,
   input wire logic [7:0] acc_addr,
   input wire logic [2:0] acc_bit,
   input wire iorsd_byte_t acc_wdata,
   // Core access answer
   output logic acc_ack,
   output logic acc_refused,
   output iorsd_byte_t acc_rdata,
   output logic acc_skip,
   // Extended space
   output logic ext_sel,
   output logic ext_we,
   output logic [7:0] ext_addr,
   output iorsd_byte_t ext_wdata,
   input wire iorsd_byte_t ext_rdata,
   // Pin levels, asynchronous
   input wire logic [7:0] pin_b_level,
   input wire logic [7:0] pin_c_level,
   input wire logic [7:0] pin_d_level,
   input wire logic [2:0] pin_e_level,
   // Peripheral status, same clock
   input wire logic pll_locked,
   input wire logic [1:0] spi_status,
   input wire logic [3:0] cmp_level,
   input wire logic rww_busy,
   // Flag events, one-cycle pulses
   input wire logic [2:0] timer8_flag_set,
   input wire logic [7:0] timer16_flag_set,
   input wire logic [3:0] pin_change_flag_set,
   input wire logic [3:0] ext_line_flag_set,
   input wire logic [3:0] cmp_flag_set,
   // Register contents
   output iorsd_space_t io_space_view
);

   // ==========================================
   // Bit masks per location: {writable, write-one-clear, read-only}
   function automatic logic [23:0] mask_of(input logic [5:0] idx);
      logic [23:0] m;
      m = {`IORSD_NO_BITS, `IORSD_NO_BITS, `IORSD_NO_BITS};
      case (idx)
         `IORSD_PIN_GROUP_B_INPUT_LEVEL,
         `IORSD_PIN_GROUP_C_INPUT_LEVEL,
         `IORSD_PIN_GROUP_D_INPUT_LEVEL: begin
            m = {`IORSD_NO_BITS, `IORSD_NO_BITS, `IORSD_ALL_BITS};
         end
         `IORSD_PIN_GROUP_E_INPUT_LEVEL: begin
            m = {`IORSD_NO_BITS, `IORSD_NO_BITS, `IORSD_THREE_BITS};
         end
         `IORSD_PIN_GROUP_B_DIRECTION, `IORSD_PIN_GROUP_B_OUTPUT_LATCH,
         `IORSD_PIN_GROUP_C_DIRECTION, `IORSD_PIN_GROUP_C_OUTPUT_LATCH,
         `IORSD_PIN_GROUP_D_DIRECTION, `IORSD_PIN_GROUP_D_OUTPUT_LATCH,
         `IORSD_GENERAL_SCRATCH_ZERO, `IORSD_GENERAL_SCRATCH_ONE,
         `IORSD_GENERAL_SCRATCH_TWO, `IORSD_NONVOLATILE_STORE_DATA,
         `IORSD_NONVOLATILE_STORE_ADDR_LOW, `IORSD_TIMER8_COUNT_VALUE,
         `IORSD_TIMER8_COMPARE_FIRST, `IORSD_TIMER8_COMPARE_SECOND,
         `IORSD_SERIAL_PORT_CONTROL, `IORSD_SERIAL_PORT_DATA,
         `IORSD_MONITOR_DATA, `IORSD_MONITOR_STOP_CONTROL: begin
            m = {`IORSD_ALL_BITS, `IORSD_NO_BITS, `IORSD_NO_BITS};
         end
         `IORSD_PIN_GROUP_E_DIRECTION, `IORSD_PIN_GROUP_E_OUTPUT_LATCH: begin
            m = {`IORSD_THREE_BITS, `IORSD_NO_BITS, `IORSD_NO_BITS};
         end
         `IORSD_TIMER8_EVENT_FLAGS: begin
            m = {`IORSD_NO_BITS, `IORSD_THREE_BITS, `IORSD_NO_BITS};
         end
         `IORSD_TIMER16_EVENT_FLAGS: begin
            m = {`IORSD_NO_BITS, `IORSD_TIMER16_FLAG_BITS, `IORSD_NO_BITS};
         end
         `IORSD_PIN_CHANGE_EVENT_FLAGS, `IORSD_EXTERNAL_LINE_EVENT_FLAGS: begin
            m = {`IORSD_NO_BITS, `IORSD_LOW_NIBBLE, `IORSD_NO_BITS};
         end
         `IORSD_EXTERNAL_LINE_EVENT_MASK, `IORSD_NONVOLATILE_STORE_CONTROL,
         `IORSD_SLEEP_CONTROL, `IORSD_RESET_CAUSE_FLAGS: begin
            m = {`IORSD_LOW_NIBBLE, `IORSD_NO_BITS, `IORSD_NO_BITS};
         end
         `IORSD_NONVOLATILE_STORE_ADDR_HIGH: begin
            m = {`IORSD_STORE_ADDR_HIGH_BITS, `IORSD_NO_BITS, `IORSD_NO_BITS};
         end
         `IORSD_SHARED_TIMER_CONTROL: begin
            m = {`IORSD_SHARED_TIMER_BITS, `IORSD_NO_BITS, `IORSD_NO_BITS};
         end
         `IORSD_TIMER8_CONTROL_FIRST: begin
            m = {`IORSD_TIMER8_FIRST_BITS, `IORSD_NO_BITS, `IORSD_NO_BITS};
         end
         `IORSD_TIMER8_CONTROL_SECOND: begin
            m = {`IORSD_TIMER8_SECOND_BITS, `IORSD_NO_BITS, `IORSD_NO_BITS};
         end
         `IORSD_PHASE_LOCK_LOOP_CONTROL: begin
            m = {`IORSD_PLL_WRITE_BITS, `IORSD_NO_BITS, `IORSD_LOWEST_BIT};
         end
         `IORSD_SERIAL_PORT_STATUS: begin
            m = {`IORSD_LOWEST_BIT, `IORSD_NO_BITS, `IORSD_SERIAL_STATUS_READ_BITS};
         end
         `IORSD_COMPARATOR_STATUS: begin
            m = {`IORSD_NO_BITS, `IORSD_COMPARATOR_FLAG_BITS, `IORSD_LOW_NIBBLE};
         end
         `IORSD_CORE_CONTROL: begin
            m = {`IORSD_CORE_CONTROL_BITS, `IORSD_NO_BITS, `IORSD_NO_BITS};
         end
         `IORSD_SELF_PROGRAM_CONTROL: begin
            m = {`IORSD_SELF_PROGRAM_WRITE_BITS, `IORSD_NO_BITS,
                 `IORSD_SELF_PROGRAM_READ_BITS};
         end
         default: begin
            m = {`IORSD_NO_BITS, `IORSD_NO_BITS, `IORSD_NO_BITS};
         end
      endcase
      return m;
   endfunction

   // ==========================================
   // Pin synchronisers
   logic [26:0] pin_sync1_reg;
   logic [26:0] pin_sync2_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_sync1_reg <= '0;
         pin_sync2_reg <= '0;
      end else if (ce) begin
         pin_sync1_reg <= {pin_b_level, pin_c_level, pin_d_level, pin_e_level};
         pin_sync2_reg <= pin_sync1_reg;
      end
   end

   // ==========================================
   // Read-only sources and flag events per location
   iorsd_byte_t ro_vec [0:63];
   iorsd_byte_t set_vec [0:63];

   always_comb begin
      for (int i = 0; i < 64; i++) begin
         ro_vec[i] = `IORSD_NO_BITS;
         set_vec[i] = `IORSD_NO_BITS;
      end
      ro_vec[`IORSD_PIN_GROUP_B_INPUT_LEVEL] = pin_sync2_reg[26:19];
      ro_vec[`IORSD_PIN_GROUP_C_INPUT_LEVEL] = pin_sync2_reg[18:11];
      ro_vec[`IORSD_PIN_GROUP_D_INPUT_LEVEL] = pin_sync2_reg[10:3];
      ro_vec[`IORSD_PIN_GROUP_E_INPUT_LEVEL] = {5'h00, pin_sync2_reg[2:0]};
      ro_vec[`IORSD_PHASE_LOCK_LOOP_CONTROL] = {7'h00, pll_locked};
      ro_vec[`IORSD_SERIAL_PORT_STATUS] = {spi_status, 6'h00};
      ro_vec[`IORSD_COMPARATOR_STATUS] = {4'h0, cmp_level};
      ro_vec[`IORSD_SELF_PROGRAM_CONTROL] = {1'b0, rww_busy, 6'h00};
      set_vec[`IORSD_TIMER8_EVENT_FLAGS] = {5'h00, timer8_flag_set};
      set_vec[`IORSD_TIMER16_EVENT_FLAGS] = timer16_flag_set;
      set_vec[`IORSD_PIN_CHANGE_EVENT_FLAGS] = {4'h0, pin_change_flag_set};
      set_vec[`IORSD_EXTERNAL_LINE_EVENT_FLAGS] = {4'h0, ext_line_flag_set};
      set_vec[`IORSD_COMPARATOR_STATUS] = {cmp_flag_set, 4'h0};
   end

   // ==========================================
   // Access decode
   iorsd_space_t store_reg;
   iorsd_space_t store_next;
   wire logic is_io = (acc_op == io_in_instr) || (acc_op == io_out_instr);
   wire logic is_data = (acc_op == indirect_load_instr) || (acc_op == indirect_store_instr);
   wire logic is_bit_wr = (acc_op == set_single_bit_instr) || (acc_op == clear_single_bit_instr);
   wire logic is_bit_test = (acc_op == skip_if_bit_one_instr) ||
                            (acc_op == skip_if_bit_zero_instr);
   wire logic is_read = (acc_op == io_in_instr) || (acc_op == indirect_load_instr);
   wire logic is_write = (acc_op == io_out_instr) || (acc_op == indirect_store_instr);
   wire logic io_ok = is_io && (acc_addr <= `IORSD_IO_TOP);
   wire logic bit_ok = (is_bit_wr || is_bit_test) && (acc_addr <= `IORSD_BIT_TOP);
   wire logic data_low = is_data && (acc_addr >= `IORSD_DATA_OFFSET) &&
                         (acc_addr < `IORSD_EXT_BASE);
   wire logic data_ext = is_data && (acc_addr >= `IORSD_EXT_BASE);
   wire logic [7:0] data_minus = acc_addr - `IORSD_DATA_OFFSET;
   wire logic [5:0] acc_idx = is_data ? data_minus[5:0] : acc_addr[5:0];
   wire logic local_hit = io_ok || bit_ok || data_low;
   wire logic taken = acc_req && ce;
   wire logic [23:0] cur_mask = mask_of(acc_idx);
   wire iorsd_byte_t cur_w1c = cur_mask[15:8];
   wire iorsd_byte_t cur_ro = cur_mask[7:0];
   // Unimplemented bits never hold a one, so reserved reads give zero
   wire iorsd_byte_t cur_rd = store_reg[acc_idx] | (ro_vec[acc_idx] & cur_ro);
   wire iorsd_byte_t bit_sel = `IORSD_LOWEST_BIT << acc_bit;
   // Flags are masked out so a bit instruction writes one to no flag but the addressed one, on a set
   wire iorsd_byte_t bit_base = cur_rd & ~cur_w1c;
   wire iorsd_byte_t bit_data = (acc_op == set_single_bit_instr) ?
                                (bit_base | bit_sel) : (bit_base & ~bit_sel);
   wire logic wr_en = taken && ((is_write && (io_ok || data_low)) || (is_bit_wr && bit_ok));
   wire iorsd_byte_t wr_data = is_bit_wr ? bit_data : acc_wdata;
   wire logic bit_now = |(cur_rd & bit_sel);
   wire logic skip_next = (acc_op == skip_if_bit_one_instr) ? bit_now : !bit_now;
   wire iorsd_byte_t rd_next = data_ext ? ext_rdata : (local_hit ? cur_rd : `IORSD_NO_BITS);

   assign ext_sel = taken && data_ext;
   assign ext_we = ext_sel && (acc_op == indirect_store_instr);
   assign ext_addr = acc_addr;
   assign ext_wdata = acc_wdata;
   assign io_space_view = store_reg;

   // ==========================================
   // Register update, event set beats a same-cycle clear
   always_comb begin
      logic [23:0] m;
      logic hit;
      iorsd_byte_t clr;
      iorsd_byte_t keep_rw;
      m = '0;
      hit = 1'b0;
      clr = '0;
      keep_rw = '0;
      for (int i = 0; i < 64; i++) begin
         m = mask_of(6'(i));
         hit = wr_en && (acc_idx == 6'(i));
         keep_rw = hit ? (wr_data & m[23:16]) : (store_reg[i] & m[23:16]);
         clr = hit ? (wr_data & m[15:8]) : `IORSD_NO_BITS;
         store_next[i] = keep_rw | (((store_reg[i] & ~clr) | set_vec[i]) & m[15:8]);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         store_reg <= '0;
      end else if (ce) begin
         store_reg <= store_next;
      end
   end

   // ==========================================
   // Answer, one cycle after the request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_ack <= 1'b0;
         acc_refused <= 1'b0;
         acc_rdata <= '0;
         acc_skip <= 1'b0;
      end else if (ce) begin
         acc_ack <= acc_req;
         acc_refused <= acc_req && !(local_hit || data_ext);
         acc_rdata <= (acc_req && is_read) ? rd_next : `IORSD_NO_BITS;
         acc_skip <= acc_req && is_bit_test && bit_ok && skip_next;
      end
   end

   // ==========================================
   // Checks
   default clocking chk_cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   wire iorsd_byte_t t8_flags = store_reg[`IORSD_TIMER8_EVENT_FLAGS];
   wire iorsd_byte_t line_flags = store_reg[`IORSD_EXTERNAL_LINE_EVENT_FLAGS];
   wire logic [7:0] line_addr = {2'b00, `IORSD_EXTERNAL_LINE_EVENT_FLAGS};

   io_range_a: assert property (taken && is_io && acc_addr > `IORSD_IO_TOP |=>
      acc_refused && acc_rdata == 8'h00)
      else $error("io access above short range not refused");

   data_offset_a: assert property (taken && acc_op == indirect_store_instr &&
      acc_addr == (`IORSD_DATA_OFFSET + {2'b00, `IORSD_GENERAL_SCRATCH_ZERO}) |=>
      store_reg[`IORSD_GENERAL_SCRATCH_ZERO] == $past(acc_wdata))
      else $error("data space store missed offset register");

   bit_range_a: assert property (taken && is_bit_wr && acc_addr > `IORSD_BIT_TOP |=>
      acc_refused && (store_reg[$past(acc_idx)] == $past(store_reg[acc_idx]) ||
      $past(set_vec[acc_idx] != `IORSD_NO_BITS)))
      else $error("bit instruction above bit range took effect");

   bit_test_a: assert property (taken && is_bit_test && bit_ok |=>
      acc_skip == $past((acc_op == skip_if_bit_one_instr) == cur_rd[acc_bit]) &&
      !acc_refused)
      else $error("bit test result wrong");

   w1c_zero_a: assert property (taken && is_write && io_ok && acc_addr == line_addr &&
      acc_wdata == 8'h00 && ext_line_flag_set == 4'h0 |=> $stable(line_flags))
      else $error("writing zero changed a flag");

   w1c_one_a: assert property (taken && is_write && io_ok && acc_addr == line_addr &&
      acc_wdata == 8'hFF && ext_line_flag_set == 4'h0 |=> line_flags == 8'h00)
      else $error("writing one did not clear flags");

   bit_only_a: assert property (taken && is_bit_wr && bit_ok &&
      acc_addr == {2'b00, `IORSD_TIMER8_EVENT_FLAGS} && timer8_flag_set == 3'h0 |=>
      (t8_flags & ~$past(bit_sel)) == ($past(t8_flags) & ~$past(bit_sel)))
      else $error("bit instruction disturbed another flag");

   ext_route_a: assert property (ext_sel |-> is_data && acc_addr >= `IORSD_EXT_BASE)
      else $error("extended space reached by short instruction");

   reserved_zero_a: assert property (taken && acc_op == io_in_instr &&
      mask_of(acc_addr[5:0]) == 24'h000000 && io_ok |=> acc_rdata == 8'h00)
      else $error("reserved location read non-zero");

   answer_time_a: assert property (taken && is_read && local_hit && !wr_en |=>
      acc_ack && acc_rdata == $past(cur_rd))
      else $error("read answer late or wrong");

   ack_once_a: assert property (ce |=> acc_ack == $past(acc_req))
      else $error("answer not one cycle after request");

   frozen_state_a: assert property (!ce |=> $stable(store_reg) && $stable(acc_ack))
      else $error("state moved while enable low");

   data_low_a: assert property (taken && is_data && acc_addr < `IORSD_DATA_OFFSET |=>
      acc_refused && acc_rdata == 8'h00)
      else $error("data access below offset served");

   ext_read_a: assert property (taken && data_ext && !ext_we |=>
      !acc_refused && acc_rdata == $past(ext_rdata))
      else $error("extended load data lost");

   refused_quiet_a: assert property (acc_refused |-> !acc_skip && acc_rdata == 8'h00)
      else $error("refused access returned data");

   set_wins_a: assert property (ce && ext_line_flag_set != 4'h0 |=>
      (line_flags[3:0] & $past(ext_line_flag_set)) == $past(ext_line_flag_set))
      else $error("flag event lost against a clear");

   reserved_write_a: assert property (taken && is_write && io_ok &&
      mask_of(acc_addr[5:0]) == 24'h000000 |=> store_reg[$past(acc_idx)] == 8'h00)
      else $error("reserved location took a write");

   bit_set_a: assert property (taken && acc_op == set_single_bit_instr &&
      acc_addr == {2'b00, `IORSD_GENERAL_SCRATCH_ZERO} |=>
      (store_reg[`IORSD_GENERAL_SCRATCH_ZERO] & $past(bit_sel)) != 8'h00)
      else $error("bit set missed");

   cover_bit_flag_c: cover property (taken && acc_op == set_single_bit_instr &&
      acc_addr == {2'b00, `IORSD_TIMER8_EVENT_FLAGS});
   cover_ext_load_c: cover property (ext_sel && !ext_we);
   cover_set_clear_c: cover property (wr_en && acc_addr == line_addr &&
      ext_line_flag_set != 4'h0);
   cover_skip_c: cover property (taken && is_bit_test ##1 acc_skip);
   cover_refused_c: cover property (taken ##1 acc_refused);

endmodule

// *** sim/iorsd_core_model.sv ***
`timescale 1ns/10ps
`include "iorsd_consts.svh"

module iorsd_core_model
   import iorsd_pkg::*;
(
   // Clock
   input wire logic clk,
   // Access request
   output logic acc_req,
   output iorsd_op_t acc_op,
   output logic [7:0] acc_addr,
   output logic [2:0] acc_bit,
   output iorsd_byte_t acc_wdata,
   // Extended space
   input wire logic ext_sel,
   input wire logic ext_we,
   input wire logic [7:0] ext_addr,
   input wire iorsd_byte_t ext_wdata,
   output iorsd_byte_t ext_rdata
);
   iorsd_byte_t mem [256];
   iorsd_byte_t last_reg;

   // Deselected bus shows inverted last value, so a stale sample cannot pass
   assign ext_rdata = ext_sel ? mem[ext_addr] : ~last_reg;

   initial begin
      acc_req = 1'b0;
      acc_op = io_in_instr;
      acc_addr = 8'h00;
      acc_bit = 3'h0;
      acc_wdata = 8'h00;
      last_reg = 8'h00;
      for (int i = 0; i < 256; i++) mem[i] = 8'h00;
   end

   always @(posedge clk) begin
      if (ext_sel) last_reg <= mem[ext_addr];
      if (ext_we) mem[ext_addr] <= ext_wdata;
   end

   // Low I/O register as seen through data space
   function automatic logic [7:0] to_data(input logic [7:0] io);
      return io + `IORSD_DATA_OFFSET;
   endfunction

   // Called just after a rising edge; held until the next one
   task automatic drive(input logic rq, input iorsd_op_t op, input logic [7:0] a,
                        input logic [2:0] b, input iorsd_byte_t d);
      acc_req <= rq;
      acc_op <= op;
      acc_addr <= a;
      acc_bit <= b;
      acc_wdata <= d;
   endtask
endmodule

// *** sim/test_io_register_space_decoder.sv ***
`timescale 1ns/10ps
`include "iorsd_consts.svh"

module test_io_register_space_decoder
   import iorsd_pkg::*;
();
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic acc_req, acc_ack, acc_refused, acc_skip, ext_sel, ext_we, pll_locked, rww_busy;
   iorsd_op_t acc_op;
   logic [7:0] acc_addr, ext_addr, pin_b, pin_c, pin_d, t16_set;
   logic [2:0] acc_bit, pin_e, t8_set;
   logic [1:0] spi_status;
   logic [3:0] cmp_level, pc_set, el_set, cmp_set;
   iorsd_byte_t acc_wdata, acc_rdata, ext_wdata, ext_rdata;
   iorsd_space_t io_space_view;
   int failures = 0;
   int check_count = 0;
   int cycles = 0;
   logic [31:0] seed = 32'hF1C9;
   int regs [64];
   int ext_m [256];
   int e_ack, e_ref, e_rd, e_skip;

   iorsd_decoder iorsd_decoder_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .acc_req(acc_req),
      .acc_op(acc_op), .acc_addr(acc_addr), .acc_bit(acc_bit), .acc_wdata(acc_wdata),
      .acc_ack(acc_ack), .acc_refused(acc_refused), .acc_rdata(acc_rdata),
      .acc_skip(acc_skip), .ext_sel(ext_sel), .ext_we(ext_we), .ext_addr(ext_addr),
      .ext_wdata(ext_wdata), .ext_rdata(ext_rdata), .pin_b_level(pin_b),
      .pin_c_level(pin_c), .pin_d_level(pin_d), .pin_e_level(pin_e),
      .pll_locked(pll_locked), .spi_status(spi_status), .cmp_level(cmp_level),
      .rww_busy(rww_busy), .timer8_flag_set(t8_set), .timer16_flag_set(t16_set),
      .pin_change_flag_set(pc_set), .ext_line_flag_set(el_set), .cmp_flag_set(cmp_set),
      .io_space_view(io_space_view));

   iorsd_core_model iorsd_core_model_inst (.clk(clk), .acc_req(acc_req), .acc_op(acc_op),
      .acc_addr(acc_addr), .acc_bit(acc_bit), .acc_wdata(acc_wdata), .ext_sel(ext_sel),
      .ext_we(ext_we), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));

   initial begin
      forever #2 clk = ~clk;
   end

   // ==========================================
   // Reference model
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic int wm(int a);
      case (a)
         8'h04, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h0B, 8'h19, 8'h1A, 8'h1E, 8'h20, 8'h21,
         8'h26, 8'h27, 8'h28, 8'h2C, 8'h2E, 8'h31, 8'h32: return 8'hFF;
         8'h0D, 8'h0E, 8'h15: return 8'h07;
         8'h1B, 8'h1C, 8'h1D, 8'h1F, 8'h33, 8'h34: return 8'h0F;
         8'h16: return 8'h27;
         8'h22: return 8'h03;
         8'h23: return 8'h81;
         8'h24: return 8'hF3;
         8'h25: return 8'hCF;
         8'h29: return 8'h06;
         8'h2D: return 8'h01;
         8'h30: return 8'hF0;
         8'h35: return 8'h93;
         8'h37: return 8'hBF;
         default: return 8'h00;
      endcase
   endfunction

   function automatic int fm(int a);
      case (a)
         8'h15: return 8'h07;
         8'h16: return 8'h27;
         8'h1B, 8'h1C: return 8'h0F;
         8'h30: return 8'hF0;
         default: return 8'h00;
      endcase
   endfunction

   function automatic int rd(int a);
      case (a)
         8'h03: return pin_b;
         8'h06: return pin_c;
         8'h09: return pin_d;
         8'h0C: return pin_e;
         8'h29: return regs[a] | pll_locked;
         8'h2D: return regs[a] | {spi_status, 6'h00};
         8'h30: return regs[a] | cmp_level;
         8'h37: return regs[a] | {rww_busy, 6'h00};
         default: return regs[a];
      endcase
   endfunction

   function automatic void wr(int a, int d);
      int m;
      m = wm(a) & ~fm(a);
      regs[a] = ((regs[a] & ~m) | (d & m)) & ~(d & fm(a));
   endfunction

   task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
      check_count++;
      if (got !== ex) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // One access per cycle; checks the answer to the previous cycle's request
   task automatic step(input logic rq, input iorsd_op_t op, input int a, input int b,
                       input int d);
      int n_ack, n_ref, n_rd, n_skip, io, bm;
      logic ls;
      logic [31:0] f;
      @(posedge clk);
      iorsd_core_model_inst.drive(rq, op, 8'(a), 3'(b), 8'(d));
      f = rnd() & rnd() & rnd();
      t8_set <= f[2:0];
      t16_set <= f[15:8];
      pc_set <= f[19:16];
      el_set <= f[23:20];
      cmp_set <= f[27:24];
      ls = op == indirect_load_instr || op == indirect_store_instr;
      io = ls ? a - 8'h20 : a;
      bm = 1 << b;
      n_ack = rq;
      n_ref = 0;
      n_rd = 0;
      n_skip = 0;
      if (rq && ls && a >= 8'h60) begin
         if (op == indirect_load_instr) n_rd = ext_m[a];
         else ext_m[a] = d;
      end else if (rq && (io < 0 || io > 8'h3F || (op > indirect_store_instr && io > 8'h1F)))
         n_ref = 1;
      else if (rq) begin
         case (op)
            io_in_instr, indirect_load_instr: n_rd = rd(io);
            io_out_instr, indirect_store_instr: wr(io, d);
            set_single_bit_instr: regs[io] = (fm(io) & bm) ? regs[io] & ~bm
                                             : regs[io] | (bm & wm(io));
            clear_single_bit_instr: if (!(fm(io) & bm)) regs[io] &= ~bm;
            skip_if_bit_one_instr: n_skip = (rd(io) & bm) != 0;
            default: n_skip = (rd(io) & bm) == 0;
         endcase
      end
      // Event pulses win over a clear in the same cycle
      regs[8'h15] |= f[2:0];
      regs[8'h16] |= f[15:8] & 8'h27;
      regs[8'h1B] |= f[19:16];
      regs[8'h1C] |= f[23:20];
      regs[8'h30] |= f[27:24] << 4;
      @(negedge clk);
      chk("ack", 8'(e_ack), 8'(acc_ack));
      chk("refused", 8'(e_ref), 8'(acc_refused));
      chk("rdata", 8'(e_rd), acc_rdata);
      chk("skip", 8'(e_skip), 8'(acc_skip));
      e_ack = n_ack;
      e_ref = n_ref;
      e_rd = n_rd;
      e_skip = n_skip;
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         failures = failures + 1;
         final_report();
      end
   end

   // ==========================================
   // Scenarios
   initial begin
      logic [31:0] r;
      iorsd_op_t op;
      int a, d;
      pin_b = rnd();
      pin_c = rnd();
      pin_d = rnd();
      pin_e = rnd();
      r = rnd();
      pll_locked = r[0];
      spi_status = r[2:1];
      cmp_level = r[6:3];
      rww_busy = r[7];
      {t8_set, t16_set, pc_set, el_set, cmp_set} = '0;
      for (int i = 0; i < 64; i++) regs[i] = 0;
      for (int i = 0; i < 256; i++) ext_m[i] = 0;
      {e_ack, e_ref, e_rd, e_skip} = '0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      // Pin levels need two edges through the synchroniser
      repeat (4) @(posedge clk);
      for (int i = 0; i <= 8'h40; i++) step(1'b1, io_in_instr, i, 0, 0);
      $display("test reset_values done");
      step(1'b1, io_out_instr, 8'h1E, 0, 8'hC3);
      step(1'b1, indirect_load_instr, iorsd_core_model_inst.to_data(8'h1E), 0, 0);
      $display("test data_alias done");
      for (int i = 0; i < 2000; i++) begin
         r = rnd();
         op = iorsd_op_t'(r[2:0]);
         a = (op == indirect_load_instr || op == indirect_store_instr) ? r[15:8]
             : (op > indirect_store_instr ? r[13:8] : r[14:8]);
         d = r[23:16];
         if (r[31] && op == io_out_instr && a < 8'h40) d = d & wm(a);
         if (r[30] && op == io_out_instr && wm(a) == 0) op = io_in_instr;
         step(r[29] | r[28], op, a, r[26:24], d);
      end
      $display("test random_access done");
      step(1'b0, io_in_instr, 0, 0, 0);
      @(posedge clk);
      @(negedge clk);
      for (int i = 0; i < 64; i++) chk("view", 8'(regs[i]), io_space_view[i]);
      $display("test register_view done");
      @(posedge clk);
      ce <= 1'b0;
      iorsd_core_model_inst.drive(1'b1, io_out_instr, 8'h1A, 3'h0, 8'(~regs[8'h1A]));
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("frozen ack", 8'h00, 8'(acc_ack));
      chk("frozen store", 8'(regs[8'h1A]), io_space_view[8'h1A]);
      $display("test clock_enable done");
      final_report();
   end
endmodule
